// ### src/keypad_pin_interrupt.sv
`timescale 1ns/1ps
`include "keypad_map.svh"

module keypad_pin_interrupt
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire keypad_pkg::keypad_addr_t reg_addr,
  input wire keypad_pkg::keypad_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output keypad_pkg::keypad_byte_t reg_rdata,
  // keypad pins
  input wire keypad_pkg::keypad_byte_t keypad_input_pin,
  // pull resistor type per pin, one selects pull-down
  output keypad_pkg::keypad_byte_t pull_down_select,
  // interrupt request to the cpu
  output logic interrupt_request
);
  import keypad_pkg::*;

  keypad_byte_t keypad_pin_enable;
  keypad_byte_t keypad_polarity_select;
  logic interrupt_request_enable;
  detect_mode_t detect_mode_select;
  logic keypad_event_flag;
  keypad_byte_t pin_sync;
  keypad_byte_t asserted_now;
  keypad_byte_t asserted_prev;
  logic edge_armed;
  logic next_event_flag;
  logic next_edge_armed;

  // true when every enabled input sits at its deasserted level
  function automatic logic all_idle(input keypad_byte_t asserted, input keypad_byte_t enable);
    all_idle = ((asserted & enable) == 8'h00);
  endfunction : all_idle

  keypad_pin_sampler u_sampler
  (
    .clk(clk),
    .nrst(nrst),
    .keypad_input_pin(keypad_input_pin),
    .pin_sync(pin_sync)
  );

  // address decode
  wire wr_sc = reg_write && (reg_addr == `KEYPAD_STATUS_CONTROL_OFFSET);
  wire wr_pe = reg_write && (reg_addr == `KEYPAD_PIN_ENABLE_OFFSET);
  wire wr_ps = reg_write && (reg_addr == `KEYPAD_POLARITY_SELECT_OFFSET);
  wire ack_write = wr_sc && reg_wdata[`FLAG_ACKNOWLEDGE_BIT];

  // asserted level per pin after polarity; masked by pin enable
  assign asserted_now = (pin_sync ~^ keypad_polarity_select) & keypad_pin_enable;
  wire [7:0] edge_hit = asserted_now & ~asserted_prev;
  wire idle_now = all_idle(asserted_now, keypad_pin_enable);
  wire edge_found = edge_armed && (edge_hit != 8'h00);
  wire level_found = (detect_mode_select == mode_edge_level) && !idle_now;

  // flag: set beats clear; level mode holds while any input asserted
  always_comb
  begin
    next_event_flag = keypad_event_flag;
    if (ack_write)
      next_event_flag = 1'b0;
    if (edge_found || level_found)
      next_event_flag = 1'b1;
  end

  // edges rearm only once all enabled inputs return idle
  always_comb
  begin
    next_edge_armed = edge_armed;
    if (edge_found)
      next_edge_armed = 1'b0;
    else if (idle_now)
      next_edge_armed = 1'b1;
  end

  // per-cycle sampling history, edge arm and event flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      asserted_prev <= 8'hFF;
      edge_armed <= 1'b0;
      keypad_event_flag <= 1'b0;
    end
    else
    begin
      asserted_prev <= asserted_now;
      edge_armed <= next_edge_armed;
      keypad_event_flag <= next_event_flag;
    end
  end

  // software registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      keypad_pin_enable <= `KEYPAD_REG_RESET;
      keypad_polarity_select <= `KEYPAD_REG_RESET;
      interrupt_request_enable <= 1'b0;
      detect_mode_select <= mode_edge_only;
    end
    else
    begin
      if (wr_pe)
        keypad_pin_enable <= reg_wdata;
      if (wr_ps)
        keypad_polarity_select <= reg_wdata;
      if (wr_sc)
      begin
        interrupt_request_enable <= reg_wdata[`INTERRUPT_REQUEST_ENABLE_BIT];
        detect_mode_select <= detect_mode_t'(reg_wdata[`DETECT_MODE_SELECT_BIT]);
      end
    end
  end

  // read mux; acknowledge and upper bits read zero
  wire [7:0] sc_view = {4'h0, keypad_event_flag, 1'b0, interrupt_request_enable,
    detect_mode_select};
  wire [7:0] rd_mux = (reg_addr == `KEYPAD_STATUS_CONTROL_OFFSET) ? sc_view :
    (reg_addr == `KEYPAD_PIN_ENABLE_OFFSET) ? keypad_pin_enable :
    (reg_addr == `KEYPAD_POLARITY_SELECT_OFFSET) ? keypad_polarity_select : 8'h00;

  // read data registered, valid the cycle after the strobe only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_read)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= 8'h00;
  end

  // request gated by enable; resistor type follows polarity
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      interrupt_request <= 1'b0;
      pull_down_select <= 8'h00;
    end
    else
    begin
      interrupt_request <= next_event_flag && interrupt_request_enable;
      pull_down_select <= keypad_polarity_select;
    end
  end
endmodule : keypad_pin_interrupt

// ### src/keypad_map.svh
`ifndef KEYPAD_MAP_SVH
`define KEYPAD_MAP_SVH

// register offsets on the plain register port
`define KEYPAD_STATUS_CONTROL_OFFSET 2'h0
`define KEYPAD_PIN_ENABLE_OFFSET 2'h1
`define KEYPAD_POLARITY_SELECT_OFFSET 2'h2

// status and control field positions
`define DETECT_MODE_SELECT_BIT 0
`define INTERRUPT_REQUEST_ENABLE_BIT 1
`define FLAG_ACKNOWLEDGE_BIT 2
`define KEYPAD_EVENT_FLAG_BIT 3

// reset values
`define KEYPAD_REG_RESET 8'h00

`endif

// ### src/keypad_pkg.sv
package keypad_pkg;
  typedef logic [7:0] keypad_byte_t;
  typedef logic [1:0] keypad_addr_t;
  typedef enum logic
  {
    mode_edge_only = 1'b0,
    mode_edge_level = 1'b1
  } detect_mode_t;
endpackage : keypad_pkg

// ### src/keypad_pin_sampler.sv
`timescale 1ns/1ps
// two-stage synchroniser for the keypad input pins
module keypad_pin_sampler
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pins in, synchronised out
  input wire keypad_pkg::keypad_byte_t keypad_input_pin,
  output keypad_pkg::keypad_byte_t pin_sync
);
  import keypad_pkg::*;

  keypad_byte_t pin_meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end
    else
    begin
      pin_meta <= keypad_input_pin;
      pin_sync <= pin_meta;
    end
  end
endmodule : keypad_pin_sampler

// ### bench/keypad_pin_interrupt_sva.sv
`timescale 1ns/1ps
// port checks of the keypad interrupt block
module keypad_pin_interrupt_sva
(
  // watched ports
  input logic clk, nrst, reg_write, reg_read, interrupt_request,
  input keypad_pkg::keypad_addr_t reg_addr,
  input keypad_pkg::keypad_byte_t reg_wdata, reg_rdata, pull_down_select
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // read port, pull type and request
  idle_data_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("data outside read");
  status_bits_a: assert property ($past(reg_read) && $past(reg_addr) == 2'h0
    |-> reg_rdata[7:4] == 4'h0 && !reg_rdata[2]) else $error("status spare bits");
  unmapped_read_a: assert property ($past(reg_read) && $past(reg_addr) == 2'h3
    |-> reg_rdata == 8'h00) else $error("unmapped read");
  pull_follow_a: assert property (reg_write && reg_addr == 2'h2
    |-> ##2 pull_down_select == $past(reg_wdata, 2)) else $error("pull type late");
  pull_hold_a: assert property (!$stable(pull_down_select)
    |-> $past(reg_write, 2) && $past(reg_addr, 2) == 2'h2) else $error("pull type moved");
  pull_read_a: assert property ($past(reg_read) && $past(reg_addr) == 2'h2
    && !$past(reg_write, 2) |-> reg_rdata == $past(pull_down_select)) else $error("pull");
  mask_clear_a: assert property (reg_write && reg_addr == 2'h0 && !reg_wdata[1]
    |-> ##2 !interrupt_request) else $error("request not masked");
  request_drop_a: assert property ($fell(interrupt_request) |->
    ($past(reg_write) && $past(reg_addr) == 2'h0) || ($past(reg_write, 2)
    && $past(reg_addr, 2) == 2'h0)) else $error("request fell alone");
endmodule : keypad_pin_interrupt_sva

bind keypad_pin_interrupt keypad_pin_interrupt_sva keypad_pin_interrupt_sva_i (.clk(clk),
  .nrst(nrst), .reg_write(reg_write), .reg_read(reg_read), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pull_down_select(pull_down_select),
  .interrupt_request(interrupt_request));

// ### bench/keypad_source.sv
`timescale 1ns/1ps
// key source: bench-chosen levels, idle before any edge
module keypad_source
(
  input keypad_pkg::keypad_byte_t press,
  output keypad_pkg::keypad_byte_t keypad_input_pin
);
  assign keypad_input_pin = press;
endmodule : keypad_source

// ### bench/test_keypad_pin_interrupt.sv
`timescale 1ns/1ps
module test_keypad_pin_interrupt;
  import keypad_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, reg_write = 1'b0, reg_read = 1'b0, interrupt_request;
  keypad_addr_t reg_addr = 2'h0;
  keypad_byte_t reg_wdata = 8'h00, press = 8'hFF, keypad_input_pin, reg_rdata, pull_down_select;
  int fail_count = 0, check_count = 0;
  // steps: op 0 write, 1 read and compare, 2 keys then no request, 3 keys then request
  localparam logic [11:0] STEPS [33] = '{
    12'h400, 12'h500, 12'h600, 12'h700, 12'h8F0,
    12'h20F, 12'h60F, 12'h1FF, 12'h5FF, 12'h0FE, 12'h402,
    12'hCF1, 12'h40A, 12'h006, 12'h8F0, 12'hCE0,
    12'hCF1, 12'h006, 12'h8F3, 12'h8F0, 12'h004, 12'h8F1, 12'h408,
    12'h8F0, 12'h007, 12'hCF1, 12'h007, 12'h40B,
    12'hCF0, 12'h007, 12'h403, 12'h101, 12'h8D0};
  // block and key source
  keypad_pin_interrupt keypad_pin_interrupt_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .keypad_input_pin, .pull_down_select, .interrupt_request);
  keypad_source keypad_source_i (.press, .keypad_input_pin);
  // clock
  initial forever #2 clk = ~clk;
  // compare one byte
  task automatic chk(input string n, input keypad_byte_t e, input keypad_byte_t g);
    check_count++;
    if (g !== e) $display("wrong value %s expected %h seen %h", n, e, g);
    if (g !== e) fail_count++;
  endtask : chk
  // one register cycle; a read compares against d
  task automatic acc(input logic r, input keypad_addr_t a, input keypad_byte_t d);
    @(posedge clk);
    {reg_write, reg_read} <= {!r, r};
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    {reg_write, reg_read} <= 2'b00;
    #1;
    if (r) chk("reg_rdata", d, reg_rdata);
  endtask : acc
  // new key levels, then the request once settled
  task automatic key(input keypad_byte_t v, input logic e);
    @(posedge clk);
    press <= v;
    repeat (6) @(posedge clk);
    #1;
    chk("interrupt_request", {7'h00, e}, {7'h00, interrupt_request});
  endtask : key
  // counts, verdict, end of run
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // watchdog
  initial
  begin
    #4000;
    fail_count++;
    print_verdict;
  end
  // step sequence
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    foreach (STEPS[i])
    begin
      if (STEPS[i][11]) key(STEPS[i][7:0], STEPS[i][10]);
      else acc(STEPS[i][10], STEPS[i][9:8], STEPS[i][7:0]);
      $display("step %0d done", i);
    end
    chk("pull_down_select", 8'h0F, pull_down_select);
    print_verdict;
  end
endmodule : test_keypad_pin_interrupt
